/* File: hw/isi_pkg.sv */
package isi_pkg;
    localparam int VEC_W = 8;
    localparam logic [7:0] VEC_DIVIDE = 8'h00;
    localparam logic [7:0] VEC_NMI = 8'h02;
    localparam logic [7:0] VEC_INV_OPCODE = 8'h06;
    localparam logic [7:0] VEC_DEV_NA = 8'h07;
    localparam logic [7:0] VEC_DOUBLE = 8'h08;
    localparam logic [7:0] VEC_INV_TASK = 8'h0A;
    localparam logic [7:0] VEC_SEG_NP = 8'h0B;
    localparam logic [7:0] VEC_STACK = 8'h0C;
    localparam logic [7:0] VEC_GEN_PROT = 8'h0D;
    localparam logic [7:0] VEC_PAGE = 8'h0E;
    localparam logic [7:0] VEC_RSVD15 = 8'h0F;
    localparam logic [7:0] VEC_FLOAT = 8'h10;
    localparam logic [7:0] VEC_ALIGN = 8'h11;
    localparam logic [7:0] VEC_MCHECK = 8'h12;
    localparam logic [7:0] VEC_RSVD_LO = 8'h14;
    localparam logic [7:0] VEC_RSVD_HI = 8'h1F;
    localparam logic [7:0] VEC_USER_LO = 8'h20;
    localparam logic [7:0] VEC_LOCAL_LO = 8'h10;
    // exception source index
    localparam int EXC_N = 12;
    localparam int EX_DIVIDE = 0;
    localparam int EX_INV_OPCODE = 1;
    localparam int EX_DEV_NA = 2;
    localparam int EX_DOUBLE = 3;
    localparam int EX_INV_TASK = 4;
    localparam int EX_SEG_NP = 5;
    localparam int EX_STACK = 6;
    localparam int EX_GEN_PROT = 7;
    localparam int EX_PAGE = 8;
    localparam int EX_FLOAT = 9;
    localparam int EX_ALIGN = 10;
    localparam int EX_MCHECK = 11;
    // event class codes
    localparam logic [1:0] CLS_FAULT = 2'h0;
    localparam logic [1:0] CLS_TRAP = 2'h1;
    localparam logic [1:0] CLS_ABORT = 2'h2;
    localparam logic [1:0] CLS_MASKABLE_REQUEST_PIN = 2'h3;
    // apb register map
    localparam logic [11:0] A_CTRL = 12'h000;
    localparam logic [11:0] A_LVT0 = 12'h004;
    localparam logic [11:0] A_LVT1 = 12'h008;
    localparam logic [11:0] A_STATUS = 12'h00C;
    localparam logic [11:0] A_LAST = 12'h010;
    localparam int CTRL_UNIT_EN = 0;
    localparam int CTRL_IF = 1;
    localparam int CTRL_MC_ERR = 2;
    localparam int ST_ILLEGAL = 0;
    localparam int ST_NMI_BUSY = 1;
    localparam logic [31:0] LVT_RESET = 32'h0000_0000;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
endpackage

/* File: hw/isi_intake.sv */
`timescale 1ns/10ps
// What this block does
// - enabled unit maps local pins via table
// - unit disabled: pin0 maskable, pin1 nonmaskable
// - maskable pin takes vector from system bus
// - nonmaskable request always services vector 2
// - never raise vectors 15, 20-31 architecturally
// - vectors 32-255 classed user interrupts
// - double fault vector 8, abort, zero code
// - vectors 10-14 faults with error code
// - alignment check vector 17, fault, zero code
// - divide error vector 0, fault, no code
// - invalid opcode vector 6, fault, no code
// - device not available vector 7, no code
// - float math fault vector 16, no code
// - machine check vector 18, abort, optional code
// - maskable pin any vector, unit 16-255
// - unit vectors 0-15 flag illegal vector; code checks forwarded messages only, not table entries
// - cleared enable flag blocks all maskable interrupts
// - software interrupt any vector, calls handler
// - software vector 2 skips nonmaskable hardware
// - software interrupts ignore enable flag
// - reset, stop, management pins bypass this block
// - take events only at instruction boundary, except the returning bus vector, which is taken whenever it arrives
module isi_intake (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] local_request_pins,
    input wire logic [7:0] sysbus_vector,
    input wire logic sysbus_vector_valid,
    output logic vector_fetch,
    input wire logic unit_msg_valid,
    input wire logic [7:0] unit_msg_vector,
    input wire logic [isi_pkg::EXC_N-1:0] exc_req,
    input wire logic soft_int_req,
    input wire logic [7:0] soft_int_vector,
    input wire logic insn_boundary,
    input wire logic nmi_handler_done,
    output logic event_valid,
    output logic [7:0] event_vector,
    output logic [1:0] event_class,
    output logic event_has_code,
    output logic event_code_zero,
    output logic event_software,
    output logic nmi_hw_active
);
    // local pins are asynchronous: two flops before use
    logic [1:0] pin_s1_r;
    logic [1:0] pin_s2_r;
    logic [1:0] pin_d_r;
    logic [31:0] ctrl_r;
    logic [7:0] lvt_r [2];
    logic illegal_r;
    logic nmi_pend_r;
    logic nmi_busy_r;
    logic maskable_request_pin_wait_r;
    logic [7:0] unit_vec_r;
    logic unit_pend_r;
    logic [7:0] last_vec_r;
    logic unit_en;
    logic if_flag;
    logic [1:0] pin_rise;
    logic mask_pin;
    logic nmi_pin_rise;
    logic wr_en;
    logic rd_en;
    logic map_hit;
    logic unit_legal;
    logic take_nmi;
    logic take_unit;
    logic take_maskable_request_pin;
    logic take_exc;
    logic take_soft;
    logic [7:0] exc_vec;
    logic [1:0] exc_cls;
    logic exc_code;
    logic exc_zero;
    int exc_idx;
    logic [1:0] pin_pend_r;
    logic [1:0] pin_pick;
    logic [7:0] unit_vec;
    logic unit_any;
    logic answer_now;
    logic bnd_ok;
    logic [1:0] maskable_request_pin_hold_r;

    assign unit_en = ctrl_r[isi_pkg::CTRL_UNIT_EN];
    assign if_flag = ctrl_r[isi_pkg::CTRL_IF];
    assign pin_rise = pin_s2_r & ~pin_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_r <= 2'h0;
            pin_s2_r <= 2'h0;
            pin_d_r <= 2'h0;
        end else if (clk_en) begin
            pin_s1_r <= local_request_pins;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    // apb slave: zero wait states, unmapped address errors
    assign pready = 1'b1;
    assign map_hit = (paddr == isi_pkg::A_CTRL) ||
        (paddr == isi_pkg::A_LVT0) || (paddr == isi_pkg::A_LVT1) ||
        (paddr == isi_pkg::A_STATUS) || (paddr == isi_pkg::A_LAST);
    assign pslverr = psel && penable && !map_hit;
    assign wr_en = psel && penable && pwrite && clk_en;
    // read data is captured in setup so it stands at the access edge
    assign rd_en = psel && !penable && !pwrite && clk_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= isi_pkg::CTRL_RESET;
            lvt_r[0] <= isi_pkg::LVT_RESET[7:0];
            lvt_r[1] <= isi_pkg::LVT_RESET[7:0];
        end else if (wr_en) begin
            unique case (paddr)
                isi_pkg::A_CTRL: ctrl_r <= {29'h0, pwdata[2:0]};
                isi_pkg::A_LVT0: lvt_r[0] <= pwdata[7:0];
                isi_pkg::A_LVT1: lvt_r[1] <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (rd_en) begin
            unique case (paddr)
                isi_pkg::A_CTRL: prdata <= ctrl_r;
                isi_pkg::A_LVT0: prdata <= {24'h0, lvt_r[0]};
                isi_pkg::A_LVT1: prdata <= {24'h0, lvt_r[1]};
                isi_pkg::A_STATUS: prdata <= {30'h0, nmi_busy_r, illegal_r};
                isi_pkg::A_LAST: prdata <= {24'h0, last_vec_r};
                default: prdata <= 32'h0;
            endcase
        end
    end

    // pin personality depends on unit enable
    assign mask_pin = !unit_en && pin_s2_r[0];
    assign nmi_pin_rise = !unit_en && pin_rise[1];

    // unit messages: forwarded vectors plus mapped local pins
    assign unit_legal = unit_msg_vector >= isi_pkg::VEC_LOCAL_LO;

    // a returning bus vector owns its cycle, so nothing else is taken then
    assign answer_now = maskable_request_pin_wait_r && sysbus_vector_valid;
    assign bnd_ok = insn_boundary && !answer_now;
    assign unit_any = unit_pend_r || (pin_pend_r != 2'h0);

    // take decisions, one event per boundary
    assign take_nmi = bnd_ok && nmi_pend_r && !nmi_busy_r;
    assign take_soft = bnd_ok && !take_nmi && soft_int_req;
    assign take_exc = bnd_ok && !take_nmi && !take_soft &&
        (exc_req != '0);
    // maskable ones gated by the enable flag, after nonmaskable
    assign take_unit = bnd_ok && if_flag && !take_nmi &&
        !take_soft && !take_exc && unit_any;
    assign take_maskable_request_pin = bnd_ok && if_flag && !take_nmi &&
        !take_soft && !take_exc && !unit_any && (maskable_request_pin_hold_r == 2'h0) &&
        mask_pin && !maskable_request_pin_wait_r;

    // vector fetch handshake from the external controller
    assign vector_fetch = maskable_request_pin_wait_r;

    // the pin level lags its synchroniser: no retake of a stale level
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            maskable_request_pin_hold_r <= 2'h0;
        end else if (clk_en) begin
            maskable_request_pin_hold_r <= {maskable_request_pin_hold_r[0], answer_now};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            maskable_request_pin_wait_r <= 1'b0;
        end else if (clk_en) begin
            if (take_maskable_request_pin) begin
                maskable_request_pin_wait_r <= 1'b1;
            end else if (sysbus_vector_valid) begin
                maskable_request_pin_wait_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_pend_r <= 1'b0;
            nmi_busy_r <= 1'b0;
        end else if (clk_en) begin
            // set wins over clear when both arrive
            if (nmi_pin_rise) begin
                nmi_pend_r <= 1'b1;
            end else if (take_nmi) begin
                nmi_pend_r <= 1'b0;
            end
            if (take_nmi) begin
                nmi_busy_r <= 1'b1;
            end else if (nmi_handler_done) begin
                nmi_busy_r <= 1'b0;
            end
        end
    end

    // one pending forwarded vector; newer arrivals overwrite it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unit_pend_r <= 1'b0;
            unit_vec_r <= 8'h00;
            illegal_r <= 1'b0;
        end else if (clk_en) begin
            if (unit_en && unit_msg_valid && unit_legal) begin
                unit_pend_r <= 1'b1;
                unit_vec_r <= unit_msg_vector;
            end else if (take_unit && pin_pick == 2'h0) begin
                unit_pend_r <= 1'b0;
            end
            if (unit_en && unit_msg_valid && !unit_legal) begin
                illegal_r <= 1'b1;
            end else if (wr_en && paddr == isi_pkg::A_STATUS &&
                    pwdata[isi_pkg::ST_ILLEGAL]) begin
                illegal_r <= 1'b0;
            end
        end
    end

    // each local pin has its own slot, so no rise is lost beside another
    for (genvar p = 0; p < $bits(pin_pend_r); p++) begin : g_pin_slot
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                pin_pend_r[p] <= 1'b0;
            end else if (clk_en) begin
                if (unit_en && pin_rise[p]) begin
                    pin_pend_r[p] <= 1'b1;
                end else if (take_unit && pin_pick[p]) begin
                    pin_pend_r[p] <= 1'b0;
                end
            end
        end
    end

    // pin 1 ahead of pin 0, both ahead of forwarded messages
    assign pin_pick[1] = pin_pend_r[1];
    assign pin_pick[0] = pin_pend_r[0] && !pin_pend_r[1];
    assign unit_vec = pin_pick[1] ? lvt_r[1] :
        (pin_pick[0] ? lvt_r[0] : unit_vec_r);

    // exception table, lowest index first
    always_comb begin
        exc_idx = 0;
        for (int i = isi_pkg::EXC_N - 1; i >= 0; i--) begin
            if (exc_req[i]) begin
                exc_idx = i;
            end
        end
        exc_vec = isi_pkg::VEC_DIVIDE;
        exc_cls = isi_pkg::CLS_FAULT;
        exc_code = 1'b0;
        exc_zero = 1'b0;
        // reserved vectors 15 and 20-31 have no entry here
        unique case (exc_idx)
            isi_pkg::EX_DIVIDE: exc_vec = isi_pkg::VEC_DIVIDE;
            isi_pkg::EX_INV_OPCODE: begin
                exc_vec = isi_pkg::VEC_INV_OPCODE;
            end
            isi_pkg::EX_DEV_NA: exc_vec = isi_pkg::VEC_DEV_NA;
            isi_pkg::EX_DOUBLE: begin
                exc_vec = isi_pkg::VEC_DOUBLE;
                exc_cls = isi_pkg::CLS_ABORT;
                exc_code = 1'b1;
                exc_zero = 1'b1;
            end
            isi_pkg::EX_INV_TASK: begin
                exc_vec = isi_pkg::VEC_INV_TASK;
                exc_code = 1'b1;
            end
            isi_pkg::EX_SEG_NP: begin
                exc_vec = isi_pkg::VEC_SEG_NP;
                exc_code = 1'b1;
            end
            isi_pkg::EX_STACK: begin
                exc_vec = isi_pkg::VEC_STACK;
                exc_code = 1'b1;
            end
            isi_pkg::EX_GEN_PROT: begin
                exc_vec = isi_pkg::VEC_GEN_PROT;
                exc_code = 1'b1;
            end
            isi_pkg::EX_PAGE: begin
                exc_vec = isi_pkg::VEC_PAGE;
                exc_code = 1'b1;
            end
            isi_pkg::EX_FLOAT: exc_vec = isi_pkg::VEC_FLOAT;
            isi_pkg::EX_ALIGN: begin
                exc_vec = isi_pkg::VEC_ALIGN;
                exc_code = 1'b1;
                exc_zero = 1'b1;
            end
            isi_pkg::EX_MCHECK: begin
                exc_vec = isi_pkg::VEC_MCHECK;
                exc_cls = isi_pkg::CLS_ABORT;
                exc_code = ctrl_r[isi_pkg::CTRL_MC_ERR];
            end
            default: ;
        endcase
    end

    // registered event output; the external vector lands a cycle late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_valid <= 1'b0;
            event_vector <= 8'h00;
            event_class <= isi_pkg::CLS_FAULT;
            event_has_code <= 1'b0;
            event_code_zero <= 1'b0;
            event_software <= 1'b0;
            last_vec_r <= 8'h00;
        end else if (clk_en) begin
            event_valid <= 1'b0;
            event_has_code <= 1'b0;
            event_code_zero <= 1'b0;
            event_software <= 1'b0;
            event_class <= isi_pkg::CLS_MASKABLE_REQUEST_PIN;
            if (take_nmi) begin
                event_valid <= 1'b1;
                event_vector <= isi_pkg::VEC_NMI;
                last_vec_r <= isi_pkg::VEC_NMI;
            end else if (take_soft) begin
                // no error code even for coded vectors
                event_valid <= 1'b1;
                event_vector <= soft_int_vector;
                event_software <= 1'b1;
                last_vec_r <= soft_int_vector;
            end else if (take_exc) begin
                event_valid <= 1'b1;
                event_vector <= exc_vec;
                event_class <= exc_cls;
                event_has_code <= exc_code;
                event_code_zero <= exc_zero;
                last_vec_r <= exc_vec;
            end else if (take_unit) begin
                event_valid <= 1'b1;
                event_vector <= unit_vec;
                last_vec_r <= unit_vec;
            end else if (maskable_request_pin_wait_r && sysbus_vector_valid) begin
                event_valid <= 1'b1;
                event_vector <= sysbus_vector;
                last_vec_r <= sysbus_vector;
            end
        end
    end

    // only the event outputs: reset and management pins never enter
    assign nmi_hw_active = nmi_busy_r;
endmodule // isi_intake

/* File: bench/isi_intake_checker.sv */
`timescale 1ns/10ps
module isi_intake_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic insn_boundary,
    input wire logic [7:0] sysbus_vector,
    input wire logic sysbus_vector_valid,
    input wire logic vector_fetch,
    input wire logic event_valid,
    input wire logic [7:0] event_vector,
    input wire logic [1:0] event_class,
    input wire logic event_has_code,
    input wire logic event_code_zero,
    input wire logic event_software,
    input wire logic nmi_hw_active
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic hw_exc;
    // interrupts may carry any vector, so only exceptions are classed here
    assign hw_exc = event_valid && !event_software
        && event_class != isi_pkg::CLS_MASKABLE_REQUEST_PIN;
    chk_nmi_vector: assert property ($rose(nmi_hw_active)
        |-> event_valid && event_vector == 8'h02 && !event_software)
        else $error("nonmaskable busy without vector 2 event");
    chk_soft_nmi: assert property (event_valid && event_software
        |-> !$rose(nmi_hw_active)) else $error("soft event set nmi busy");
    chk_reserved: assert property (hw_exc |->
        !(event_vector == 8'h0F || event_vector inside {[8'h14:8'h1F]}))
        else $error("reserved vector raised");
    chk_double_abort: assert property (hw_exc && event_vector == 8'h08
        |-> event_class == 2'h2 && event_has_code && event_code_zero)
        else $error("double fault form wrong");
    chk_code_faults: assert property (hw_exc &&
        event_vector inside {[8'h0A:8'h0E]} |-> event_class == 2'h0
        && event_has_code) else $error("code fault form wrong");
    chk_align_form: assert property (hw_exc && event_vector == 8'h11
        |-> event_class == 2'h0 && event_has_code && event_code_zero)
        else $error("alignment check form wrong");
    chk_no_code: assert property (hw_exc &&
        event_vector inside {8'h00, 8'h06, 8'h07, 8'h10} |->
        event_class == 2'h0 && !event_has_code) else $error("fault had code");
    chk_user_class: assert property (event_valid && !event_software
        && event_vector >= 8'h20 |-> event_class == isi_pkg::CLS_MASKABLE_REQUEST_PIN)
        else $error("user vector not interrupt class");
    chk_at_boundary: assert property (event_valid &&
        !($past(sysbus_vector_valid) && $past(vector_fetch))
        |-> $past(insn_boundary)) else $error("event off boundary");
    chk_fetch_answer: assert property (vector_fetch && sysbus_vector_valid
        |=> event_valid && event_vector == $past(sysbus_vector)
        && !vector_fetch) else $error("bus vector not delivered");
    cov_nmi: cover property ($rose(nmi_hw_active));
    cov_soft: cover property (event_valid && event_software);
    cov_fetch: cover property (vector_fetch && sysbus_vector_valid);
    cov_abort: cover property (hw_exc && event_class == 2'h2);
endmodule // isi_intake_checker

bind isi_intake isi_intake_checker u_chk (
    .pclk(pclk), .presetn(presetn), .insn_boundary(insn_boundary),
    .sysbus_vector(sysbus_vector), .sysbus_vector_valid(sysbus_vector_valid),
    .vector_fetch(vector_fetch), .event_valid(event_valid),
    .event_vector(event_vector), .event_class(event_class),
    .event_has_code(event_has_code), .event_code_zero(event_code_zero),
    .event_software(event_software), .nmi_hw_active(nmi_hw_active)
);

/* File: bench/isi_ext_ctrl.sv */
`timescale 1ns/10ps
module isi_ext_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic vector_fetch,
    input wire logic [7:0] give_vector,
    input wire logic [3:0] lag,
    output logic [7:0] sysbus_vector,
    output logic sysbus_vector_valid
);
    logic [3:0] wait_r;
    logic done_r;
    // bus undriven between answers: a toggling pattern, so a late read fails
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wait_r <= 4'h0;
            done_r <= 1'h0;
            sysbus_vector <= 8'hA5;
            sysbus_vector_valid <= 1'h0;
        end else begin
            sysbus_vector_valid <= 1'h0;
            sysbus_vector <= ~sysbus_vector;
            if (!vector_fetch) begin
                wait_r <= 4'h0;
                done_r <= 1'h0;
            end else if (!done_r && wait_r == lag) begin
                sysbus_vector <= give_vector;
                sysbus_vector_valid <= 1'h1;
                done_r <= 1'h1;
            end else if (!done_r) begin
                wait_r <= wait_r + 4'h1;
            end
        end
    end
endmodule // isi_ext_ctrl

/* File: bench/isi_intake_tb_top.sv */
`timescale 1ns/10ps
module isi_intake_tb_top;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, umq = 1'h0, siq = 1'h0, bnd = 1'h1, done_p = 1'h0;
    logic [11:0] paddr = 12'h000, exc = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [1:0] pins = 2'h0, ev_cls;
    logic [7:0] umv = 8'h00, siv = 8'h00, cvec = 8'h05, sbv, ev_vec;
    logic [3:0] clag = 4'h0;
    logic ce = 1'h1;
    logic pready, pslverr, fetch, sbq, ev_v, ev_code, ev_zero, ev_sw, nmi, serr;
    int err_count = 0, checks = 0;
    isi_intake DUT (.pclk(pclk), .presetn(presetn), .clk_en(ce),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .local_request_pins(pins), .sysbus_vector(sbv),
        .sysbus_vector_valid(sbq), .vector_fetch(fetch), .unit_msg_valid(umq),
        .unit_msg_vector(umv), .exc_req(exc), .soft_int_req(siq),
        .soft_int_vector(siv), .insn_boundary(bnd), .nmi_handler_done(done_p),
        .event_valid(ev_v), .event_vector(ev_vec), .event_class(ev_cls),
        .event_has_code(ev_code), .event_code_zero(ev_zero),
        .event_software(ev_sw), .nmi_hw_active(nmi));
    isi_ext_ctrl u_ctrl (.pclk(pclk), .presetn(presetn), .vector_fetch(fetch),
        .give_vector(cvec), .lag(clag), .sysbus_vector(sbv),
        .sysbus_vector_valid(sbq));
    initial begin
        forever #25 pclk = ~pclk;
    end
    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // read data and response are taken at the edge that sees pready
    task automatic apb(input logic w, input logic [11:0] a, input int d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= 32'(d);
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        serr = pslverr;
        rd = prdata;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    task automatic ev(input logic [12:0] e, m);
        int k;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (ev_v !== 1'h1 && k < 40);
        chk("event", {1'h1, e & m},
            {ev_v, {ev_vec, ev_cls, ev_code, ev_zero, ev_sw} & m});
    endtask
    task automatic quiet(input int n);
        logic s;
        s = 1'h0;
        repeat (n) begin
            @(posedge pclk);
            s = s | ev_v | fetch;
        end
        chk("quiet", 32'h0, 32'(s));
    endtask
    task automatic t_regs();
        apb(0, isi_pkg::A_CTRL, 0);
        chk("ctrl reset", 32'h0, rd);
        apb(1, isi_pkg::A_LVT0, 32'h40);
        apb(0, isi_pkg::A_LVT0, 0);
        chk("lvt0", 32'h40, rd);
        apb(0, 12'h014, 0);
        chk("unmapped", 32'h1, 32'(serr));
        $display("t_regs done");
    endtask
    task automatic t_exc();
        logic [7:0] vt [12] = '{8'h00, 8'h06, 8'h07, 8'h08, 8'h0A, 8'h0B,
            8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h11, 8'h12};
        logic ab, cd, zr;
        for (int i = 0; i < 12; i++) begin
            ab = (i == 3 || i == 11);
            cd = (i >= 3 && i <= 8) || i == 10;
            zr = (i == 3 || i == 10);
            @(posedge pclk);
            exc <= 12'h001 << i;
            @(posedge pclk);
            exc <= 12'h000;
            ev({vt[i], ab, 1'h0, cd, zr, 1'h0},
                {10'h3FF, 1'h1, zr, 1'h1});
        end
        // a frozen block leaves a standing exception alone until it runs
        apb(1, isi_pkg::A_CTRL, 32'h4);
        ce <= 1'h0;
        exc <= 12'h800;
        quiet(4);
        ce <= 1'h1;
        @(posedge pclk);
        exc <= 12'h000;
        ev({8'h12, 2'h2, 3'h4}, 13'h1FFF);
        $display("t_exc done");
    endtask
    task automatic t_soft();
        logic [7:0] sv [4] = '{8'h23, 8'h02, 8'hFF, 8'h00};
        for (int i = 0; i < 4; i++) begin
            @(posedge pclk);
            siq <= 1'h1;
            siv <= sv[i];
            @(posedge pclk);
            siq <= 1'h0;
            ev({sv[i], 5'h01}, 13'h1FE1);
            chk("nmi busy", 32'h0, 32'(nmi));
        end
        $display("t_soft done");
    endtask
    // both pins raised off boundary: nonmaskable must go first
    task automatic t_pins();
        apb(1, isi_pkg::A_CTRL, 32'h2);
        bnd <= 1'h0;
        pins <= 2'h3;
        quiet(8);
        bnd <= 1'h1;
        ev({8'h02, 2'h3, 3'h0}, 13'h1FF9);
        chk("nmi busy", 32'h1, 32'(nmi));
        // the fetch is under way: drop the level so it is not taken again
        pins <= 2'h0;
        ev({8'h05, 2'h3, 3'h0}, 13'h1FF9);
        done_p <= 1'h1;
        @(posedge pclk);
        done_p <= 1'h0;
        apb(1, isi_pkg::A_CTRL, 32'h0);
        chk("nmi done", 32'h0, 32'(nmi));
        pins <= 2'h1;
        cvec <= 8'h80;
        clag <= 4'h5;
        quiet(12);
        apb(1, isi_pkg::A_CTRL, 32'h2);
        pins <= 2'h0;
        ev({8'h80, 2'h3, 3'h0}, 13'h1FF9);
        $display("t_pins done");
    endtask
    task automatic t_unit();
        apb(1, isi_pkg::A_LVT1, 32'h21);
        apb(1, isi_pkg::A_CTRL, 32'h3);
        pins <= 2'h2;
        ev({8'h21, 2'h3, 3'h0}, 13'h1FF9);
        chk("nmi busy", 32'h0, 32'(nmi));
        pins <= 2'h3;
        ev({8'h40, 2'h3, 3'h0}, 13'h1FF9);
        pins <= 2'h0;
        umq <= 1'h1;
        umv <= 8'h10;
        @(posedge pclk);
        umq <= 1'h0;
        ev({8'h10, 2'h3, 3'h0}, 13'h1FF9);
        umq <= 1'h1;
        umv <= 8'h0F;
        @(posedge pclk);
        umq <= 1'h0;
        quiet(6);
        apb(0, isi_pkg::A_STATUS, 0);
        chk("illegal", 32'h1, 32'(rd[0]));
        apb(1, isi_pkg::A_STATUS, 1);
        apb(0, isi_pkg::A_STATUS, 0);
        chk("illegal clear", 32'h0, 32'(rd[0]));
        $display("t_unit done");
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        t_regs();
        t_exc();
        t_soft();
        t_pins();
        t_unit();
        test_done();
    end
    // all tests take well under 1000 cycles; 4000 means a hang
    initial begin
        #200000;
        err_count++;
        test_done();
    end
endmodule // isi_intake_tb_top
